// ---- verilog/asr_top.sv ----
`timescale 1ns/1ps
module asr_top
  import asr_pkg::*;
(
  // System clock and reset.
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // Conversion engine side.
  input  wire logic [DATA_W-1:0]   sample_i,
  input  wire asr_pkg::asr_mode_t  mode_i,
  input  wire logic [RATE_W-1:0]   output_rate_select_i,
  output logic                     sample_taken_o,
  // Serial link, clocked by its own serial clock; the output enable and the command outputs are registered on clk_i.
  input  wire logic                sclk_i,
  input  wire logic                cs_n_i,
  input  wire logic                din_i,
  output logic                     dout_rdy_o,
  output logic                     dout_rdy_oe_n_o,
  output logic [CMD_W-1:0]         cmd_o,
  output logic                     cmd_valid_o
);
  import asr_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Conversion timer and result FIFO in the system domain.

  logic [23:0]       rate_cnt_reg;
  logic [23:0]       rate_cnt_next;
  logic [23:0]       rate_load;
  logic              update;
  logic              single_done_reg;
  logic              conv_en;
  logic              sample_taken_reg;

  asr_fifo_if #(.WIDTH(DATA_W)) fin ();
  asr_fifo_if #(.WIDTH(DATA_W)) fout ();

  assign conv_en = (mode_i == ASR_MODE_CONT) ||
                   ((mode_i == ASR_MODE_SINGLE) && !single_done_reg);
  assign update  = conv_en && (rate_cnt_reg == 24'h00_0000);
  // The counter runs from period-1 down to zero, one update per period.
  assign rate_load     = asr_rate_cycles(output_rate_select_i) - 24'h00_0001;
  assign rate_cnt_next = update ? rate_load
                       : (conv_en ? rate_cnt_reg - 24'h00_0001 : rate_cnt_reg);
  assign fin.data  = sample_i;
  // A result is dropped if the FIFO is full, as a real converter would
  // simply overwrite an unread word.
  assign fin.valid = update;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rate_cnt_reg     <= 24'h00_0000;
      single_done_reg  <= 1'b0;
      sample_taken_reg <= 1'b0;
    end else begin
      rate_cnt_reg     <= rate_cnt_next;
      single_done_reg  <= (mode_i == ASR_MODE_SINGLE) &&
                          (single_done_reg || update);
      sample_taken_reg <= update && fin.ready;
    end
  end

  assign sample_taken_o = sample_taken_reg;

  asr_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .wr       (fin.sink),
    .rd       (fout.src)
  );

  //////////////////////////////////////////////////////////////////////////
  // Result holding register, handshake to the link domain.

  logic [DATA_W-1:0] hold_reg;
  logic              rdy_n_reg;
  logic              read_tgl_s1_reg;
  logic              read_tgl_s2_reg;
  logic              read_tgl_s3_reg;
  logic              read_done_sys;
  logic              load_hold;
  logic              ack_tgl_reg;

  assign read_done_sys = read_tgl_s2_reg ^ read_tgl_s3_reg;
  // Every new result replaces the held one, so a read-data reread always returns the
  // latest result and the buffer never backs up behind an unread word.
  assign fout.ready = 1'b1;
  assign load_hold  = fout.valid;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_reg        <= DATA_RESET;
      rdy_n_reg       <= 1'b1;
      read_tgl_s1_reg <= 1'b0;
      read_tgl_s2_reg <= 1'b0;
      read_tgl_s3_reg <= 1'b0;
    end else begin
      read_tgl_s1_reg <= ack_tgl_reg;
      read_tgl_s2_reg <= read_tgl_s1_reg;
      read_tgl_s3_reg <= read_tgl_s2_reg;
      if (load_hold) begin
        hold_reg  <= fout.data;
        rdy_n_reg <= 1'b0;
      end else if (read_done_sys) begin
        // A new result in the same cycle as a finished read wins.
        rdy_n_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Link domain: frame state on the serial clock, cleared while deselected.

  logic              frame_clr;
  logic [5:0]        edge_cnt_reg;
  logic [CMD_W-1:0]  cmd_shift_reg;
  logic [CMD_W-1:0]  cmd_byte;
  logic [DATA_W-1:0] shift_reg;
  logic              reading_reg;
  logic              word_read_reg;
  logic              dout_reg;
  logic              cmd_end;
  logic              word_end;
  logic              is_read;
  logic              cread_block;
  logic              rdy_s1_reg;
  logic              rdy_s2_reg;
  logic [CMD_W-1:0]  cmd_reg;
  logic              cmd_tgl_reg;

  assign frame_clr   = cs_n_i || !arst_n_i;
  // The byte completes on the eighth rising edge, with that edge's bit.
  assign cmd_byte    = {cmd_shift_reg[CMD_W-2:0], din_i};
  assign cmd_end     = (edge_cnt_reg == 6'(CMD_W - 1));
  assign word_end    = reading_reg &&
                       (edge_cnt_reg == 6'(CMD_W + DATA_W - 1));
  assign is_read     = (cmd_byte == CMD_READ_DATA) ||
                       (cmd_byte == CMD_CREAD_ON);
  // In continuous read a word already read is not offered again.
  assign cread_block = (cmd_byte == CMD_CREAD_ON) && rdy_s2_reg;

  // Rising edge: host bits are taken and the host samples the line.
  always_ff @(posedge sclk_i or posedge frame_clr) begin
    if (frame_clr) begin
      edge_cnt_reg  <= 6'h00;
      cmd_shift_reg <= '0;
      shift_reg     <= DATA_RESET;
      reading_reg   <= 1'b0;
      word_read_reg <= 1'b0;
    end else begin
      cmd_shift_reg <= cmd_byte;
      if (edge_cnt_reg != '1) begin
        edge_cnt_reg <= edge_cnt_reg + 6'h01;
      end
      if (cmd_end && is_read && !cread_block) begin
        reading_reg <= 1'b1;
        shift_reg   <= hold_reg;
      end else if (word_end) begin
        reading_reg   <= 1'b0;
        word_read_reg <= 1'b1;
      end else if (reading_reg) begin
        shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
      end
    end
  end

  // Link state that outlives a frame: command hand-off, read acknowledge
  // and the ready flag brought over from the system domain.
  always_ff @(posedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdy_s1_reg  <= 1'b1;
      rdy_s2_reg  <= 1'b1;
      cmd_reg     <= '0;
      cmd_tgl_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
    end else begin
      rdy_s1_reg <= rdy_n_reg;
      rdy_s2_reg <= rdy_s1_reg;
      if (cmd_end) begin
        cmd_reg     <= cmd_byte;
        cmd_tgl_reg <= ~cmd_tgl_reg;
      end
      if (word_end) begin
        ack_tgl_reg <= ~ack_tgl_reg;
      end
    end
  end

  // Falling edge is the active edge: the next bit follows it.
  always_ff @(negedge sclk_i or posedge frame_clr) begin
    if (frame_clr) begin
      dout_reg <= 1'b1;
    end else begin
      dout_reg <= shift_reg[DATA_W-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output pin: data while a word shifts, high once read, else ready.

  logic cs_s1_reg;
  logic cs_s2_reg;

  // Data must follow the serial clock itself, so the level is a select of
  // link and ready registers rather than a system clock register.
  assign dout_rdy_o = reading_reg   ? dout_reg :
                      word_read_reg ? 1'b1 : rdy_n_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_s1_reg       <= 1'b1;
      cs_s2_reg       <= 1'b1;
      dout_rdy_oe_n_o <= 1'b1;
    end else begin
      cs_s1_reg       <= cs_n_i;
      cs_s2_reg       <= cs_s1_reg;
      dout_rdy_oe_n_o <= cs_s2_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command bytes handed to the system domain.

  logic cmd_s1_reg;
  logic cmd_s2_reg;
  logic cmd_s3_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_s1_reg  <= 1'b0;
      cmd_s2_reg  <= 1'b0;
      cmd_s3_reg  <= 1'b0;
      cmd_o       <= '0;
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_s1_reg  <= cmd_tgl_reg;
      cmd_s2_reg  <= cmd_s1_reg;
      cmd_s3_reg  <= cmd_s2_reg;
      cmd_valid_o <= cmd_s2_reg ^ cmd_s3_reg;
      if (cmd_s2_reg ^ cmd_s3_reg) begin
        cmd_o <= cmd_reg;
      end
    end
  end

endmodule // asr_top

// ---- verilog/asr_pkg.sv ----
package asr_pkg;

  // Result word width and output rate select width.
  localparam int unsigned DATA_W       = 24;
  localparam int unsigned RATE_W       = 4;
  localparam int unsigned CMD_W        = 8;
  localparam int unsigned FIFO_DEPTH   = 4;

  // System clock period in nanoseconds, as driven by the testbench clock.
  localparam int unsigned CLK_PERIOD_NS = 50;

  // Conversion period per rate code, in system clock cycles.
  localparam int unsigned RATE_BASE_CYC = 256;

  // Operating modes of the conversion engine.
  typedef enum logic [1:0] {
    ASR_MODE_CONT,
    ASR_MODE_SINGLE,
    ASR_MODE_IDLE,
    ASR_MODE_POWERDOWN
  } asr_mode_t;

  // Command byte fields: read-data command and continuous-read toggle.
  localparam logic [CMD_W-1:0] CMD_READ_DATA   = 8'h58;
  localparam logic [CMD_W-1:0] CMD_CREAD_ON    = 8'h5C;
  localparam logic [CMD_W-1:0] CMD_CREAD_OFF   = 8'h58;
  localparam logic [RATE_W-1:0] RATE_RESET     = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET     = 24'h00_0000;

  // Cycles between result updates for a rate code.
  function automatic logic [23:0] asr_rate_cycles(
    input logic [RATE_W-1:0] code
  );
    asr_rate_cycles = 24'(RATE_BASE_CYC) * (24'(code) + 24'h00_0001);
  endfunction

endpackage

// ---- verilog/asr_fifo_if.sv ----
`timescale 1ns/1ps
interface asr_fifo_if #(
  parameter int unsigned WIDTH = 24
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src  (output data, output valid, input ready);
  modport sink (input data, input valid, output ready);
endinterface

// ---- verilog/asr_fifo.sv ----
`timescale 1ns/1ps
module asr_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Fill side and drain side.
  asr_fifo_if.sink  wr,
  asr_fifo_if.src   rd
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full     = (wptr_reg[AW] != rptr_reg[AW]) &&
                    (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  assign empty    = (wptr_reg == rptr_reg);
  assign push     = wr.valid && !full;
  assign pop      = rd.ready && !empty;
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rptr_reg[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_reg + (AW+1)'(push);
      rptr_reg <= rptr_reg + (AW+1)'(pop);
    end
  end

endmodule // asr_fifo

// ---- dv/asr_top_monitor.sv ----
`timescale 1ns/1ps
module asr_top_monitor (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Watched ports.
  input wire logic cs_n_i,
  input wire logic dout_rdy_oe_n_o,
  input wire logic sample_taken_o,
  input wire logic cmd_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [11:0] gap_reg;
  logic        seen_reg;
  // Counts cycles since the last result entered the buffer.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap_reg  <= '0;
      seen_reg <= 1'b0;
    end else if (sample_taken_o) begin
      gap_reg  <= '0;
      seen_reg <= 1'b1;
    end else if (gap_reg != 12'hFFF) begin
      gap_reg <= gap_reg + 12'h001;
    end
  end
  sequence sel_held;
    !cs_n_i [*4];
  endsequence
  sequence desel_held;
    cs_n_i [*4];
  endsequence
  chk_drive_sel:
    assert property ($fell(cs_n_i) |-> ##[1:3] !dout_rdy_oe_n_o)
    else $error("Line not driven after select.");
  chk_release_desel:
    assert property ($rose(cs_n_i) |-> ##[1:3] dout_rdy_oe_n_o)
    else $error("Line not released after deselect.");
  chk_hold_drive:
    assert property (sel_held |-> !dout_rdy_oe_n_o)
    else $error("Line released while selected.");
  chk_hold_float:
    assert property (desel_held |-> dout_rdy_oe_n_o)
    else $error("Line driven while deselected.");
  chk_cmd_pulse:
    assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("Command strobe longer than one cycle.");
  chk_quiet_idle:
    assert property (cs_n_i [*8] |-> !cmd_valid_o)
    else $error("Command strobe without a frame.");
  chk_taken_pulse:
    assert property (sample_taken_o |=> !sample_taken_o)
    else $error("Result strobe longer than one cycle.");
  chk_rate_gap:
    assert property (sample_taken_o && seen_reg |-> gap_reg >= 12'd255)
    else $error("Results closer than the shortest period.");
endmodule // asr_top_monitor
bind asr_top asr_top_monitor mon (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .cs_n_i(cs_n_i), .dout_rdy_oe_n_o(dout_rdy_oe_n_o),
  .sample_taken_o(sample_taken_o), .cmd_valid_o(cmd_valid_o));

// ---- dv/asr_host_model.sv ----
`timescale 1ns/1ps
module asr_host_model (
  // Serial link.
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic line_i
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end
  // Deselected clock pulses, used only while reset is held.
  task automatic flush();
    repeat (2) begin
      #6 sclk_o = 1'b0;
      #6 sclk_o = 1'b1;
    end
  endtask
  // One frame: command byte out, then 24 result bits in, MSB first.
  task automatic xfer(input logic [7:0] cmd, output logic rdy_n,
                      output logic [23:0] word, output logic hi);
    cs_n_o = 1'b0;
    #160 rdy_n = line_i;
    for (int i = 31; i >= 0; i--) begin
      sclk_o = 1'b0;
      if (i > 23) din_o = cmd[i-24];
      #6;
      if (i < 24) word[i] = line_i;
      sclk_o = 1'b1;
      #6;
    end
    #20 hi = line_i;
    cs_n_o = 1'b1;
    din_o = ~din_o;
    #200;
  endtask
endmodule // asr_host_model

// ---- dv/asr_top_tb.sv ----
`timescale 1ns/1ps
module asr_top_tb;
  import asr_pkg::*;
  localparam logic [DATA_W-1:0] WORD_A = 24'hA5_3C96;
  logic              clk_i    = 1'b0;
  logic              arst_n_i = 1'b0;
  logic              flt      = 1'b0;
  logic [RATE_W-1:0] rate     = 4'h3;
  asr_mode_t         mode     = ASR_MODE_CONT;
  logic              taken, sclk, cs_n, din, dout, oe_n, cmd_valid;
  logic [CMD_W-1:0]  cmd;
  int                miscompares = 0;
  int                num_checks  = 0;
  int                cycles      = 0;
  // A released line shows a level that changes every cycle.
  wire line = oe_n ? flt : dout;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    flt <= ~flt;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  asr_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .sample_i(WORD_A),
    .mode_i(mode), .output_rate_select_i(rate),
    .sample_taken_o(taken), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .dout_rdy_o(dout), .dout_rdy_oe_n_o(oe_n), .cmd_o(cmd),
    .cmd_valid_o(cmd_valid));
  asr_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .line_i(line));
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  // Waits for a fresh result so a frame never straddles an update.
  task automatic wait_update();
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (taken !== 1'b1 && n < 1100);
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_rate();
    int n;
    wait_update();
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (taken !== 1'b1 && n < 3000);
    check(n == 4 * RATE_BASE_CYC - 3, "update period");
    @(posedge clk_i);
    rate <= 4'h0;
    $display("t_rate end");
  endtask
  task automatic t_read();
    logic r1, r2, h1, h2;
    logic [23:0] w1, w2;
    wait_update();
    host.xfer(CMD_READ_DATA, r1, w1, h1);
    host.xfer(CMD_READ_DATA, r2, w2, h2);
    check(r1 === 1'b0, "ready before read");
    check(w1 === WORD_A, "first word");
    check(h1 === 1'b1, "line high after word");
    check(r2 === 1'b1, "ready after read");
    check(w2 === WORD_A, "reread word");
    check(cmd === CMD_READ_DATA, "command byte");
    $display("t_read end");
  endtask
  task automatic t_cread();
    logic r1, r2, h1, h2;
    logic [23:0] w1, w2;
    wait_update();
    host.xfer(CMD_CREAD_ON, r1, w1, h1);
    host.xfer(CMD_CREAD_ON, r2, w2, h2);
    check(r1 === 1'b0 && w1 === WORD_A, "streamed word");
    check(r2 === 1'b1, "word offered twice");
    check(w2 === 24'hFF_FFFF, "line idle when refused");
    wait_update();
    host.xfer(CMD_CREAD_OFF, r1, w1, h1);
    check(r1 === 1'b0 && w1 === WORD_A, "next streamed word");
    $display("t_cread end");
  endtask
  task automatic t_single();
    int n;
    @(posedge clk_i);
    mode <= ASR_MODE_SINGLE;
    n = 0;
    repeat (3 * RATE_BASE_CYC) begin
      @(negedge clk_i);
      if (taken === 1'b1) begin
        n++;
      end
    end
    check(n == 1, "single conversion count");
    @(posedge clk_i);
    mode <= ASR_MODE_CONT;
    $display("t_single end");
  endtask
  task automatic results();
    $display("Checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    host.flush();
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_rate();
    t_read();
    t_cread();
    t_single();
    results();
  end
endmodule // asr_top_tb
